/* File: hdl/wwdt_params.svh */
`ifndef WWDT_PARAMS_SVH
`define WWDT_PARAMS_SVH

// register byte offsets
`define WWDT_OFF_CR 8'h00
`define WWDT_OFF_MR 8'h04
`define WWDT_OFF_SR 8'h08

// reset values
`define WWDT_CFG_RESET 32'h3FFF_2FFF
`define WWDT_FLG_RESET 32'h0000_0000
`define WWDT_CFG_MASK 32'h3FFF_FFFF

// restart command fields
`define WWDT_KEY 8'hA5
`define WWDT_KEY_HI 31
`define WWDT_KEY_LO 24
`define WWDT_RESTART_BIT 0

// status fields
`define WWDT_FLG_UNF_BIT 0
`define WWDT_FLG_ERR_BIT 1

// slow clock prescaler
`define WWDT_SLOW_DIV 8'h80

`endif

/* File: hdl/wwdt_pkg.sv */
package wwdt_pkg;

   // configuration register layout, msb first
   typedef struct packed {
      logic [1:0] rsvd;
      logic halt_in_idle;
      logic halt_in_debug;
      logic [11:0] restart_window_value;
      logic counter_disable;
      logic processor_only_reset_select;
      logic reset_on_fault_enable;
      logic fault_interrupt_enable;
      logic [11:0] reload_value;
   } wwdt_mode_t;

   // prescaler state
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic [6:0] cnt;
      logic tick;
   } wwdt_pre_st_t;

   // watchdog core and bus state
   typedef struct packed {
      wwdt_mode_t mode;
      logic locked;
      logic [11:0] counter;
      logic underflow_flag;
      logic window_error_flag;
      logic irq;
      logic fault;
      logic rst_all;
      logic ack;
      logic [31:0] rdata;
   } wwdt_st_t;

   // fault requests to the outside
   typedef struct packed {
      logic irq;
      logic fault;
      logic rst_all;
      logic rst_proc;
   } wwdt_fault_t;

endpackage

/* File: hdl/wwdt_prescaler.sv */
`include "wwdt_params.svh"

// divides the synchronised slow clock into a one-cycle tick
module wwdt_prescaler #(
   parameter logic [7:0] DIV = `WWDT_SLOW_DIV
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_clk_i,
   input wire logic run_i,
   input wire logic clear_i,
   output logic tick_o
);

   wwdt_pkg::wwdt_pre_st_t q;
   wwdt_pkg::wwdt_pre_st_t d;
   logic edge_seen;
   logic [6:0] last;

   assign last = 7'(DIV - 8'h01);
   assign edge_seen = q.sync2 && !q.prev;

   // two-flop synchroniser, then divide rising edges
   always_comb begin
      d = q;
      d.sync1 = slow_clk_i;
      d.sync2 = q.sync1;
      d.prev = q.sync2;
      d.tick = 1'b0;
      if (clear_i) begin
         d.cnt = 7'h00;
      end else if (run_i && edge_seen) begin
         if (q.cnt == last) begin
            d.cnt = 7'h00;
            d.tick = 1'b1;
         end else begin
            d.cnt = 7'(q.cnt + 7'h01);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick_o = q.tick;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_tick_period: assert property (
      run_i && edge_seen && !clear_i && q.cnt == last |=> tick_o)
      else $error("prescaler did not tick after last slow edge");

   a_clear_restart: assert property (
      clear_i |=> q.cnt == 7'h00 && !tick_o)
      else $error("prescaler not cleared by restart");

endmodule

/* File: hdl/wwdt_top.sv */
// Our own choice: the Wishbone slave port.
`include "wwdt_params.svh"

// Overview of operation
// - three registers; status reads zero after reset
// - configuration resets to 0x3FFF_2FFF
// - configuration accepts one write per reset
// - restart write needs key 0xA5 on top
// - keyed write with bit0 set restarts
// - bits 11:0 give the reload value
// - interrupt enable routes faults to interrupt
// - reset enable routes faults to reset
// - bit 14 picks processor-only reset
// - restart allowed when counter within window
// - restart above window flags an error
// - debug halt stops counter in debug
// - idle halt stops counter in idle
// - disable bit stops the counter
// - underflow flag sticky until status read
// - window error flag sticky until read
// - counter ticks on slow clock /128
// - restart reloads counter and clears prescaler
// - underflow sets flag; fault line only with reset enable
// - status read or reset clears the flags and fault requests
module wwdt_top #(
   parameter logic [7:0] SLOW_DIV = `WWDT_SLOW_DIV
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic slow_clk_i,
   input wire logic debug_i,
   input wire logic idle_i,
   output logic irq_o,
   output logic fault_o,
   output logic rst_all_req_o,
   output logic rst_proc_req_o
);

   wwdt_pkg::wwdt_st_t q;
   wwdt_pkg::wwdt_st_t d;
   wwdt_pkg::wwdt_fault_t req;

   logic take;
   logic wr_cr;
   logic wr_mr;
   logic rd_sr;
   logic key_ok;
   logic restart_cmd;
   logic in_window;
   logic restart_ok;
   logic win_err_ev;
   logic run_en;
   logic tick;
   logic unf_ev;
   logic fault_ev;
   logic reload;
   logic [31:0] mr_merged;

   // byte address match; the low two bits must be zero
   function automatic logic addr_is(input logic [7:0] adr,
                                    input logic [7:0] off);
      return adr == off;
   endfunction

   // merge write data into a word under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // a request is taken once, in the cycle before ack
   assign take = wb_cyc_i && wb_stb_i && !q.ack;
   assign wr_cr = take && wb_we_i && addr_is(wb_adr_i, `WWDT_OFF_CR);
   assign wr_mr = take && wb_we_i && addr_is(wb_adr_i, `WWDT_OFF_MR);
   assign rd_sr = take && !wb_we_i && addr_is(wb_adr_i, `WWDT_OFF_SR);

   // key lane and restart lane must both be enabled
   assign key_ok = wb_sel_i[3] &&
      wb_dat_i[`WWDT_KEY_HI:`WWDT_KEY_LO] == `WWDT_KEY;
   assign restart_cmd = wr_cr && key_ok && wb_sel_i[0] &&
      wb_dat_i[`WWDT_RESTART_BIT];

   // window check holds even while the counter is disabled
   assign in_window =
      q.counter <= q.mode.restart_window_value;
   assign restart_ok = restart_cmd && in_window;
   assign win_err_ev = restart_cmd && !in_window;

   // counter runs unless disabled or halted by debug or idle
   assign run_en = !q.mode.counter_disable &&
      !(q.mode.halt_in_debug && debug_i) &&
      !(q.mode.halt_in_idle && idle_i);

   // the first configuration write after reset also reloads and restarts
   assign reload = restart_ok || (wr_mr && !q.locked);

   assign unf_ev = tick && run_en && !reload &&
      q.counter == 12'h000;
   assign fault_ev = unf_ev || win_err_ev;

   assign mr_merged = merge(q.mode, wb_dat_i, wb_sel_i) &
      `WWDT_CFG_MASK;

   // prescaler is cleared along with every reload
   wwdt_prescaler #(
      .DIV(SLOW_DIV)
   ) u_prescaler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .slow_clk_i(slow_clk_i),
      .run_i(run_en),
      .clear_i(reload),
      .tick_o(tick)
   );

   // next state of the whole block
   always_comb begin
      d = q;
      d.ack = take;

      // write-once configuration: later writes fall away silently
      if (wr_mr && !q.locked) begin
         d.mode = wwdt_pkg::wwdt_mode_t'(mr_merged);
         d.locked = 1'b1;
      end

      // down counter; underflow reloads so faults keep repeating
      if (restart_ok) begin
         d.counter = q.mode.reload_value;
      end else if (wr_mr && !q.locked) begin
         d.counter = d.mode.reload_value;
      end else if (tick && run_en) begin
         if (q.counter == 12'h000) begin
            d.counter = q.mode.reload_value;
         end else begin
            d.counter = 12'(q.counter - 12'h001);
         end
      end

      // sticky flags: a new event wins over a clearing read
      d.underflow_flag = (q.underflow_flag && !rd_sr) ||
         unf_ev;
      d.window_error_flag = (q.window_error_flag && !rd_sr) ||
         win_err_ev;

      // interrupt and reset requests held until status read
      d.irq = (q.irq && !rd_sr) ||
         (fault_ev && q.mode.fault_interrupt_enable);
      d.fault = (q.fault && !rd_sr) ||
         (fault_ev && q.mode.reset_on_fault_enable);
      d.rst_all = (q.rst_all && !rd_sr) ||
         (fault_ev && q.mode.reset_on_fault_enable &&
          !q.mode.processor_only_reset_select);
      if (rd_sr) begin
         d.irq = d.irq && fault_ev;
      end

      // read data; restart register and holes read as zero
      d.rdata = 32'h0000_0000;
      if (take && !wb_we_i) begin
         if (addr_is(wb_adr_i, `WWDT_OFF_MR)) begin
            d.rdata = q.mode;
         end else if (addr_is(wb_adr_i, `WWDT_OFF_SR)) begin
            d.rdata[`WWDT_FLG_UNF_BIT] = q.underflow_flag;
            d.rdata[`WWDT_FLG_ERR_BIT] = q.window_error_flag;
         end
      end
   end

   // reset restores configuration and unlocks it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.mode <= wwdt_pkg::wwdt_mode_t'(`WWDT_CFG_RESET);
         q.counter <= 12'hFFF;
      end else begin
         q <= d;
      end
   end

   // outputs straight from state
   assign req.irq = q.irq;
   assign req.fault = q.fault;
   assign req.rst_all = q.rst_all;
   assign req.rst_proc = q.fault;
   assign irq_o = req.irq;
   assign fault_o = req.fault;
   assign rst_all_req_o = req.rst_all;
   assign rst_proc_req_o = req.rst_proc;
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdata;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_reset_state: assert property (
      $fell(rst_i) |-> !q.underflow_flag && !q.window_error_flag &&
         !irq_o && !fault_o && !q.locked)
      else $error("status not clear after reset");

   a_mode_reset: assert property (
      $fell(rst_i) |-> q.mode == `WWDT_CFG_RESET)
      else $error("configuration reset value wrong");

   a_mode_once: assert property (
      q.locked && wr_mr |=> $stable(q.mode) && q.locked)
      else $error("locked configuration was changed");

   a_mode_first: assert property (
      !q.locked && wr_mr && wb_sel_i == 4'hF |=>
         q.mode == ($past(wb_dat_i) & `WWDT_CFG_MASK) &&
         q.counter == q.mode.reload_value)
      else $error("first configuration write not taken");

   a_bad_key: assert property (
      wr_cr && wb_dat_i[31:24] != `WWDT_KEY |=>
         !$rose(q.window_error_flag) &&
         ($past(tick) || $stable(q.counter)))
      else $error("unkeyed restart had an effect");

   a_bad_key_nop: assert property (
      wr_cr && !key_ok |-> !restart_ok && !win_err_ev)
      else $error("unkeyed restart accepted");

   a_restart_load: assert property (
      restart_cmd && q.counter <= q.mode.restart_window_value |=>
         q.counter == q.mode.reload_value)
      else $error("restart inside window did not reload");

   a_bit0_zero: assert property (
      wr_cr && !wb_dat_i[0] |-> !restart_ok && !win_err_ev)
      else $error("restart with bit0 clear acted");

   a_window_err: assert property (
      restart_cmd && q.counter > q.mode.restart_window_value |=>
         q.window_error_flag && wb_ack_o)
      else $error("restart above window not flagged");

   a_irq_route: assert property (
      fault_ev && q.mode.fault_interrupt_enable |=> irq_o)
      else $error("fault did not raise interrupt");

   a_irq_quiet: assert property (
      !q.mode.fault_interrupt_enable && !irq_o |=> !irq_o)
      else $error("interrupt raised while disabled");

   a_fault_line: assert property (
      fault_ev && q.mode.reset_on_fault_enable |=>
         fault_o && rst_proc_req_o)
      else $error("fault did not reach reset line");

   a_fault_quiet: assert property (
      !q.mode.reset_on_fault_enable && !fault_o |=> !fault_o)
      else $error("reset line raised while disabled");

   a_reset_type: assert property (
      fault_o && !rd_sr |=> rst_all_req_o ==
         ($past(rst_all_req_o) ||
          ($past(fault_ev) && !q.mode.processor_only_reset_select)))
      else $error("reset type does not follow select bit");

   a_halt_debug: assert property (
      q.mode.halt_in_debug && debug_i && !reload |=>
         $stable(q.counter))
      else $error("counter moved while halted in debug");

   a_halt_idle: assert property (
      q.mode.halt_in_idle && idle_i && !reload |=>
         $stable(q.counter))
      else $error("counter moved while halted in idle");

   a_disabled: assert property (
      q.mode.counter_disable && !reload |=> $stable(q.counter))
      else $error("disabled counter moved");

   a_count_step: assert property (
      tick && run_en && !reload && q.counter != 12'h000 |=>
         q.counter == $past(q.counter) - 12'h001)
      else $error("counter did not step on tick");

   a_underflow: assert property (
      unf_ev |=> q.underflow_flag && q.counter == q.mode.reload_value)
      else $error("underflow not flagged or reloaded");

   a_sr_clear: assert property (
      rd_sr && !fault_ev |=> !q.underflow_flag &&
         !q.window_error_flag && !irq_o && !fault_o ##1 !wb_ack_o)
      else $error("status read did not clear flags");

   a_sr_read: assert property (
      rd_sr |=> wb_dat_o[1:0] ==
         {$past(q.window_error_flag), $past(q.underflow_flag)})
      else $error("status read data wrong");

   a_bus_ack: assert property (
      take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not one cycle");

   a_ack_only_taken: assert property (
      !take |=> !wb_ack_o)
      else $error("bus answer without a request");

   a_hole_reads_zero: assert property (
      take && !wb_we_i && wb_adr_i != `WWDT_OFF_MR &&
         wb_adr_i != `WWDT_OFF_SR |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped or write-only read not zero");

   a_proc_only: assert property (
      q.mode.processor_only_reset_select && !rst_all_req_o |=>
         !rst_all_req_o)
      else $error("all resets asked for in processor-only mode");

   a_count_hold: assert property (
      !tick && !reload |=> $stable(q.counter))
      else $error("counter moved without a tick");

   a_unf_sticky: assert property (
      q.underflow_flag && !rd_sr |=> q.underflow_flag)
      else $error("underflow flag lost without a read");

   a_err_sticky: assert property (
      q.window_error_flag && !rd_sr |=> q.window_error_flag)
      else $error("window error flag lost without a read");

   a_key_lanes: assert property (
      wr_cr && !(wb_sel_i[3] && wb_sel_i[0]) |-> !restart_cmd)
      else $error("restart taken with a lane disabled");

endmodule

/* File: sim/wwdt_slow_src.sv */
// free-running slow clock source standing in for the low-power oscillator
module wwdt_slow_src #(
   parameter int HALF = 4
) (
   input wire logic clk_i,
   output logic slow_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic slow_q = 1'b0;
   // toggles every HALF system cycles; the real source runs free too
   always @(posedge clk_i) begin
      if (cnt == HALF - 1) begin
         cnt <= 0;
         slow_q <= ~slow_q;
      end else begin
         cnt <= cnt + 1;
      end
   end
   // a single driver for the pin
   assign slow_clk_o = slow_q;
endmodule

/* File: sim/testbench.sv */
// watchdog bench: short prescaler, slow clock period of 8 system cycles
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic dbg = 1'b0;
   logic idl = 1'b0;
   logic slow;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic ack, irq, flt, rall, rproc;
   logic [11:0] rl;
   logic [31:0] cfg_w;
   logic [31:0] cmds [3] = '{32'hA500_0001, 32'hA500_0000, 32'h5A00_0001};
   logic [31:0] exps [3] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0001};
   int err_count = 0;
   int n_checks = 0;
   int cycles = 0;

   always #10 clk_i = ~clk_i;

   wwdt_slow_src src (.clk_i(clk_i), .slow_clk_o(slow));

   wwdt_top #(.SLOW_DIV(8'h04)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .slow_clk_i(slow),
      .debug_i(dbg), .idle_i(idl), .irq_o(irq), .fault_o(flt),
      .rst_all_req_o(rall), .rst_proc_req_o(rproc)
   );

   // expected configuration word, built field by field
   function automatic logic [31:0] cfg(input logic [11:0] rv, win,
                                       input logic ie, re, ps, ds, hd, hi);
      return {2'b00, hi, hd, win, ds, ps, re, ie, rv};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // classic single cycle: hold everything until ack is sampled high
   task automatic wb_cycle(input logic w, input logic [7:0] a,
                           input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic wait_fault(input int n);
      int i;
      i = 0;
      while (flt !== 1'b1 && i < n) begin
         @(posedge clk_i);
         i++;
      end
   endtask

   task automatic do_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      wait_cyc(6);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // hang guard: whole run needs well under this many cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         finish_test();
      end
   end

   initial begin
      void'($urandom(32'h5B43F7FF));
      rl = 12'h004 + 12'($urandom_range(2, 0));
      wait_cyc(6);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // map, reset values, unmapped and write-only reads
      wb_cycle(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0000);
      wb_cycle(1'b0, 8'h04, 32'h0);
      check(rd, 32'h3FFF_2FFF);
      wb_cycle(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0000_0000);
      wb_cycle(1'b0, 8'h0C, 32'h0);
      check(rd, 32'h0000_0000);
      // one write locks; an early keyed restart is a window error
      cfg_w = cfg(rl, 12'h001, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      wb_cycle(1'b1, 8'h04, cfg_w);
      wb_cycle(1'b1, 8'h04, 32'h0000_8FFF);
      wb_cycle(1'b0, 8'h04, 32'h0);
      check(rd, cfg_w);
      wb_cycle(1'b1, 8'h00, 32'hA500_0001);
      wait_cyc(2);
      check(32'({irq, flt, rall, rproc}), 32'h0000_000F);
      wb_cycle(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0002);
      wait_cyc(2);
      check(32'({irq, flt, rall, rproc}), 32'h0000_0000);
      wb_cycle(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0000);
      wait_fault(700);
      check(32'(flt), 32'h0000_0001);
      wb_cycle(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0001);
      // disabled counter, processor-only reset, no interrupt
      do_reset;
      cfg_w = cfg(rl, 12'h001, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      wb_cycle(1'b1, 8'h04, cfg_w);
      wait_cyc(400);
      check(32'(flt), 32'h0000_0000);
      wb_cycle(1'b1, 8'h00, 32'hA500_0001);
      wait_cyc(2);
      check(32'({irq, flt, rall, rproc}), 32'h0000_0005);
      wb_cycle(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0002);
      // debug and idle halts freeze the count
      do_reset;
      cfg_w = cfg(rl, rl, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      wb_cycle(1'b1, 8'h04, cfg_w);
      dbg <= 1'b1;
      wait_cyc(400);
      check(32'(flt), 32'h0000_0000);
      dbg <= 1'b0;
      idl <= 1'b1;
      wait_cyc(400);
      check(32'(flt), 32'h0000_0000);
      idl <= 1'b0;
      wait_fault(700);
      check(32'(flt), 32'h0000_0001);
      wb_cycle(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0001);
      // periodic restarts: keyed, bit 0 clear, wrong key; the first
      // restart lands while the counter equals the window value
      for (int k = 0; k < 3; k++) begin
         do_reset;
         cfg_w = cfg(rl, rl, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
         wb_cycle(1'b1, 8'h04, cfg_w);
         wb_cycle(1'b1, 8'h00, cmds[k]);
         repeat (6) begin
            wait_cyc(80);
            wb_cycle(1'b1, 8'h00, cmds[k]);
         end
         wb_cycle(1'b0, 8'h08, 32'h0);
         check(rd, exps[k]);
      end
      finish_test();
   end
endmodule
